// [rtl/prfh_cfg.svh]
/*
  Constants for the upper physical request filter: register byte offsets,
  field positions, reset values and node-ID layout.
  Assumes it is included by bare name from the rtl/ folder.
*/
`ifndef PRFH_CFG_SVH
`define PRFH_CFG_SVH

`define PRFH_ADDR_W        9
`define PRFH_SET_OFS       9'h110
`define PRFH_CLR_OFS       9'h114
`define PRFH_STAT_OFS      9'h128
`define PRFH_FILT_RST      32'h0000_0000
`define PRFH_STAT_RST      32'h0000_0000
`define PRFH_REMOTE_BIT    31
`define PRFH_NODE_BITS     31
`define PRFH_LOCAL_BUS     10'h3FF
`define PRFH_BCAST_NODE    6'h3F
`define PRFH_STAT_CNT_LSB  16
`define PRFH_CODE_NONE     3'h0
`define PRFH_CODE_PHYS     3'h1
`define PRFH_CODE_ASYNC    3'h2
`define PRFH_CODE_REJECT   3'h3
`define PRFH_CODE_OTHER    3'h4

`endif

// [rtl/prfh_filter.sv]
/*
  Upper physical request filter: set/clear register pair on an Avalon-MM
  slave with one wait state, plus the per-request routing decision.
  Assumes a single clock, synchronous request inputs and a master that
  holds its request until it samples waitrequest low.
*/
// The Avalon-MM register port was left to the implementer.
// Function
// - filter at a set and clear address
// - top bit accepts all remote-bus nodes
// - bit n selects local node n plus 32
// - set node bit routes to physical context
// - asynchronous filter checked before physical filter
// - clear node bit routes to asynchronous context
// - filter resets to all zeros
// - asynchronous stage accepts only enabled nodes
`timescale 1ns/1ps
`include "prfh_cfg.svh"

module prfh_filter
  import prfh_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [`PRFH_ADDR_W-1:0]  avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     req_valid,
  input  wire logic [15:0]              req_src_id,
  input  wire logic                     req_to_phys,
  input  wire logic [31:0]              node_async_accept_enable,
  output logic                          route_valid,
  output logic                          route_phys,
  output logic                          route_async,
  output logic                          route_reject,
  output logic                          route_not_upper,
  output logic                          accept_remote_bus_nodes,
  output logic [31:0]                   phys_filter
);

  prfh_bus_st_t   bus_st_r;
  prfh_word_t     filt_r;
  prfh_word_t     rdata_r;
  prfh_word_t     be_mask;
  prfh_route_t    last_rt_r;
  prfh_route_t    rt_nxt;
  logic [15:0]    phys_cnt_r;
  logic           hit_set;
  logic           hit_clr;
  logic           hit_stat;
  logic           wr_take;
  logic           in_upper;
  logic           async_ok;
  logic           phys_ok;
  logic           rv_r;
  logic           rphys_r;
  logic           rasync_r;
  logic           rrej_r;
  logic           rother_r;
  logic [2:0]     rt_code;

  // address decode; exact compare so misaligned addresses count as unmapped
  assign hit_set  = (avs_address == `PRFH_SET_OFS);
  assign hit_clr  = (avs_address == `PRFH_CLR_OFS);
  assign hit_stat = (avs_address == `PRFH_STAT_OFS);

  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // one wait state: the first cycle of every request stalls, the second ends it
  assign avs_waitrequest = (avs_read | avs_write) & (bus_st_r == PRFH_BUS_IDLE);
  assign wr_take         = avs_write & (bus_st_r == PRFH_BUS_ACK);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_st_r <= PRFH_BUS_IDLE;
    end else begin
      case (bus_st_r)
        PRFH_BUS_IDLE: begin
          if (avs_read | avs_write) begin
            bus_st_r <= PRFH_BUS_ACK;
          end
        end
        PRFH_BUS_ACK: begin
          bus_st_r <= PRFH_BUS_IDLE;
        end
        default: begin
          bus_st_r <= PRFH_BUS_IDLE;
        end
      endcase
    end
  end

  // read data is captured in the stall cycle so it stands at the ack edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= `PRFH_FILT_RST;
    end else if (avs_read && bus_st_r == PRFH_BUS_IDLE) begin
      if (hit_set || hit_clr) begin
        rdata_r <= filt_r;
      end else if (hit_stat) begin
        rdata_r <= {phys_cnt_r, 13'h0000, rt_code};
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  assign avs_readdata = rdata_r;

  // only one bus write per cycle, so set and clear never collide
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_r <= `PRFH_FILT_RST;
    end else if (wr_take && hit_set) begin
      filt_r <= filt_r | (avs_writedata & be_mask);
    end else if (wr_take && hit_clr) begin
      filt_r <= filt_r & ~(avs_writedata & be_mask);
    end
  end

  assign phys_filter             = filt_r;
  assign accept_remote_bus_nodes = filt_r[`PRFH_REMOTE_BIT];

  prfh_route i_prfh_route (
    .src_id     (req_src_id),
    .phys_filt  (filt_r),
    .async_filt (node_async_accept_enable),
    .in_upper   (in_upper),
    .async_ok   (async_ok),
    .phys_ok    (phys_ok)
  );

  // the asynchronous filter is consulted first; physical filter only after it
  always_comb begin
    rt_nxt = PRFH_RT_NONE;
    if (!in_upper) begin
      rt_nxt = PRFH_RT_OTHER;
    end else if (!async_ok) begin
      rt_nxt = PRFH_RT_REJECT;
    end else if (req_to_phys && phys_ok) begin
      rt_nxt = PRFH_RT_PHYS;
    end else begin
      rt_nxt = PRFH_RT_ASYNC;
    end
  end

  // valid is a one-cycle pulse, kept apart from the flags that must hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rv_r <= 1'b0;
    end else begin
      rv_r <= req_valid;
    end
  end

  // routing flags hold until the next request; a filter write in the same
  // cycle as a request is not seen by it, the old filter decides
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rphys_r  <= 1'b0;
      rasync_r <= 1'b0;
      rrej_r   <= 1'b0;
      rother_r <= 1'b0;
    end else if (req_valid) begin
      rphys_r  <= (rt_nxt == PRFH_RT_PHYS);
      rasync_r <= (rt_nxt == PRFH_RT_ASYNC);
      rrej_r   <= (rt_nxt == PRFH_RT_REJECT);
      rother_r <= (rt_nxt == PRFH_RT_OTHER);
    end
  end

  assign route_valid     = rv_r;
  assign route_phys      = rphys_r;
  assign route_async     = rasync_r;
  assign route_reject    = rrej_r;
  assign route_not_upper = rother_r;

  // status: last outcome of the routing decision
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_rt_r <= PRFH_RT_NONE;
    end else if (req_valid) begin
      last_rt_r <= rt_nxt;
    end
  end

  // grant count wraps; software must read differences, not totals
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phys_cnt_r <= 16'(`PRFH_STAT_RST);
    end else if (req_valid && rt_nxt == PRFH_RT_PHYS) begin
      phys_cnt_r <= phys_cnt_r + 16'h0001;
    end
  end

  always_comb begin
    case (last_rt_r)
      PRFH_RT_NONE: begin
        rt_code = `PRFH_CODE_NONE;
      end
      PRFH_RT_PHYS: begin
        rt_code = `PRFH_CODE_PHYS;
      end
      PRFH_RT_ASYNC: begin
        rt_code = `PRFH_CODE_ASYNC;
      end
      PRFH_RT_REJECT: begin
        rt_code = `PRFH_CODE_REJECT;
      end
      PRFH_RT_OTHER: begin
        rt_code = `PRFH_CODE_OTHER;
      end
      default: begin
        rt_code = `PRFH_CODE_NONE;
      end
    endcase
  end

endmodule : prfh_filter

// [rtl/prfh_pkg.sv]
/*
  Types shared by the upper physical request filter modules.
  Assumes prfh_cfg.svh is compiled alongside; holds no constants itself.
*/
package prfh_pkg;

  typedef logic [31:0] prfh_word_t;
  typedef logic [15:0] prfh_node_id_t;

  typedef enum logic [1:0] {
    PRFH_BUS_IDLE,
    PRFH_BUS_ACK
  } prfh_bus_st_t;

  typedef enum logic [2:0] {
    PRFH_RT_NONE,
    PRFH_RT_PHYS,
    PRFH_RT_ASYNC,
    PRFH_RT_REJECT,
    PRFH_RT_OTHER
  } prfh_route_t;

endpackage : prfh_pkg

// [rtl/prfh_route.sv]
/*
  Combinational node-ID comparison against the upper asynchronous and
  physical filters. Assumes node IDs are 10-bit bus number over 6-bit node.
*/
`timescale 1ns/1ps
`include "prfh_cfg.svh"

module prfh_route
  import prfh_pkg::*;
(
  input  wire prfh_node_id_t src_id,
  input  wire prfh_word_t    phys_filt,
  input  wire prfh_word_t    async_filt,
  output logic               in_upper,
  output logic               async_ok,
  output logic               phys_ok
);

  logic [9:0]                        bus_num;
  logic [5:0]                        node_num;
  logic                              remote;
  logic [`PRFH_NODE_BITS-1:0]        node_hit;

  assign bus_num  = src_id[15:6];
  assign node_num = src_id[5:0];
  assign remote   = (bus_num != `PRFH_LOCAL_BUS);

  // one decoder line per node 32..62; bit n is node n+32
  genvar i;
  generate
    for (i = 0; i < `PRFH_NODE_BITS; i++) begin : g_hit
      assign node_hit[i] = node_num[5] & (node_num[4:0] == 5'(i));
    end
  endgenerate

  // local broadcast node 63 and local nodes below 32 belong to other filters; every remote-bus node stays here
  assign in_upper = remote | (node_num[5] & (node_num != `PRFH_BCAST_NODE));

  always_comb begin
    if (remote) begin
      async_ok = async_filt[`PRFH_REMOTE_BIT];
      phys_ok  = phys_filt[`PRFH_REMOTE_BIT];
    end else begin
      async_ok = |(node_hit & async_filt[`PRFH_NODE_BITS-1:0]);
      phys_ok  = |(node_hit & phys_filt[`PRFH_NODE_BITS-1:0]);
    end
  end

endmodule : prfh_route

// [verification/prfh_filter_props.sv]
/* assertion checker for the upper request filter
   assumes one clock and a bind onto prfh_filter */
`timescale 1ns/1ps
module prfh_filter_props
  import prfh_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [8:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        req_valid,
  input wire logic [15:0] req_src_id,
  input wire logic        req_to_phys,
  input wire logic [31:0] node_async_accept_enable,
  input wire logic        route_valid,
  input wire logic        route_phys,
  input wire logic        route_async,
  input wire logic        route_reject,
  input wire logic        route_not_upper,
  input wire logic [31:0] phys_filter
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // remote node 63 is left open, so only the p_lat antecedent covers it
  wire logic       loc = req_src_id[15:6] == 10'h3FF;
  wire logic [5:0] nd  = req_src_id[5:0];
  wire logic [4:0] bi  = loc ? 5'(nd - 6'h20) : 5'h1F;
  wire logic       up  = req_valid && nd != 6'h3F && (!loc || nd > 6'h1F);
  wire logic       ok  = up && node_async_accept_enable[bi];
  wire logic       wr  = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
  sequence s_ans;
    route_valid && $onehot({route_phys, route_async, route_reject, route_not_upper});
  endsequence
  property p_lat; req_valid |=> s_ans; endproperty
  property p_set; wr && avs_address == 9'h110
    |=> phys_filter == ($past(phys_filter) | $past(avs_writedata)); endproperty
  property p_clr; wr && avs_address == 9'h114
    |=> phys_filter == ($past(phys_filter) & ~$past(avs_writedata)); endproperty
  property p_rst; $rose(rst_n) |-> phys_filter == 32'h0000_0000; endproperty
  property p_rej; up && !node_async_accept_enable[bi] |=> route_reject; endproperty
  property p_phys; ok |=> route_phys == $past(req_to_phys && phys_filter[bi]); endproperty
  property p_async; ok && !(req_to_phys && phys_filter[bi]) |=> route_async; endproperty
  property p_rem; ok && !loc && req_to_phys && phys_filter[31] |=> route_phys; endproperty
  a_lat: assert property (p_lat) else $error("route answer");
  a_set: assert property (p_set) else $error("set write");
  a_clr: assert property (p_clr) else $error("clear write");
  a_rst: assert property (p_rst) else $error("reset value");
  a_rej: assert property (p_rej) else $error("reject");
  a_phys: assert property (p_phys) else $error("phys route");
  a_async: assert property (p_async) else $error("async route");
  a_rem: assert property (p_rem) else $error("remote route");
endmodule : prfh_filter_props
bind prfh_filter prfh_filter_props i_prfh_filter_props (.*);

// [verification/prfh_node_model.sv]
/* node source: one request per go pulse
   assumes go, id and ph change just after a rising edge */
`timescale 1ns/1ps
module prfh_node_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        go,
  input wire logic [15:0] id,
  input wire logic        ph,
  output logic            req_valid,
  output logic [15:0]     req_src_id,
  output logic            req_to_phys
);
  // idle lines toggle so a stale id never passes for a live one
  always_ff @(posedge clk) begin
    req_valid   <= rst_n && go;
    req_src_id  <= !rst_n ? 16'h0000 : go ? id : ~req_src_id;
    req_to_phys <= !rst_n ? 1'b0 : go ? ph : !req_to_phys;
  end
endmodule : prfh_node_model

// [verification/tb_phys_request_filter_high.sv]
/* bench for prfh_filter: filter model, node source, Avalon master
   assumes rtl/ on the include path */
`timescale 1ns/1ps
module tb_phys_request_filter_high
  import prfh_pkg::*;
;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, go, ph, req_valid;
  logic        req_to_phys, route_valid, route_phys, route_async, route_reject;
  logic        route_not_upper, accept_remote_bus_nodes;
  logic [3:0]  avs_byteenable;
  logic [8:0]  avs_address;
  logic [15:0] req_src_id, id;
  logic [31:0] avs_writedata, avs_readdata, node_async_accept_enable, phys_filter, filt, q;
  int          failures, compares;
  int          grants;
  logic [2:0]  last;
  prfh_filter     i_prfh_filter (.*);
  prfh_node_model i_prfh_node_model (.*);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic miss(input string m);
    failures++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : miss
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) miss("filter word");
  endtask : chk_word
  task automatic chk_rt(input logic [3:0] g, input logic [3:0] e);
    compares++;
    if (g !== e) miss("route flags");
  endtask : chk_rt
  // sel 0: waitrequest low, sel 1: route answer up
  function automatic bit done(input bit sel);
    return sel ? route_valid === 1'b1 : avs_waitrequest === 1'b0;
  endfunction : done
  // pre-edge sample; a hang ends the run
  task automatic wait_on(input bit sel);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!done(sel) && n < 50);
    if (!done(sel)) begin
      miss("timeout");
      final_report();
    end
  endtask : wait_on
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    wait_on(1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read  <= 0;
  endtask : bus
  function automatic logic [3:0] exp_rt(logic [15:0] s, logic p, logic [31:0] a);
    int b;
    b = s[15:6] != 10'h3FF ? 31 : s[5:0] - 32;
    if (b < 0 || (b == 31 && s[15:6] == 10'h3FF)) return 4'h1;
    if (!a[b]) return 4'h2;
    return p && filt[b] ? 4'h8 : 4'h4;
  endfunction : exp_rt
  task automatic rt(input logic [15:0] s, input logic p);
    logic [31:0] a;
    logic [3:0]  e;
    a = $urandom;
    @(posedge clk);
    go <= 1;
    id <= s;
    ph <= p;
    node_async_accept_enable <= a;
    @(posedge clk);
    go <= 0;
    wait_on(1'b1);
    e = exp_rt(s, p, a);
    chk_rt({route_phys, route_async, route_reject, route_not_upper}, e);
    grants += int'(e == 4'h8);
    last = e[3] ? 3'h1 : e[2] ? 3'h2 : e[1] ? 3'h3 : 3'h4;
  endtask : rt
  initial begin
    logic [31:0] d, m;
    logic [15:0] s;
    logic [8:0]  a;
    d = $urandom(32'h04DF);
    {rst_n, avs_read, avs_write, go, ph, avs_address, avs_writedata, id} <= '0;
    node_async_accept_enable <= '0;
    avs_byteenable           <= 4'hF;
    {filt, failures, compares, grants, last} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    bus(0, 9'h110, 0);
    chk_word(q, 0);
    bus(1, 9'h100, '1);
    bus(0, 9'h114, 0);
    chk_word(q, 0);
    for (int k = 0; k < 80; k++) begin
      a = $urandom % 2 ? 9'h114 : 9'h110;
      d = $urandom;
      avs_byteenable <= k % 4 ? 4'hF : 4'($urandom);
      @(posedge clk);
      m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
           {8{avs_byteenable[0]}}};
      filt = a == 9'h110 ? filt | d & m : filt & ~(d & m);
      bus(1, a, d);
      bus(0, a ^ 9'h004, 0);
      chk_word(q, filt);
      chk_word({accept_remote_bus_nodes, phys_filter[30:0]}, filt);
      repeat (3) begin
        case ($urandom % 4)
          0: s = {10'($urandom % 1023), 6'($urandom)};
          1: s = {10'h3FF, 6'(32 + $urandom % 31)};
          default: s = {10'h3FF, 6'($urandom)};
        endcase
        rt(s, 1'($urandom));
      end
      bus(0, 9'h128, 0);
      chk_word(q, {grants[15:0], 13'h0000, last});
    end
    // a reset in mid-run must clear a fully set filter and the status word
    avs_byteenable <= 4'hF;
    bus(1, 9'h110, 32'hFFFF_FFFF);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    {filt, grants, last} = '0;
    bus(0, 9'h114, 0);
    chk_word(q, 0);
    chk_word(phys_filter, 0);
    bus(0, 9'h128, 0);
    chk_word(q, 0);
    final_report();
  end
endmodule : tb_phys_request_filter_high
